// ===== rtl/swk_defines.svh
`ifndef SWK_DEFINES_SVH
`define SWK_DEFINES_SVH

`define SWK_CLK_MHZ           250
`define SWK_OSC_MHZ           50
`define SWK_OSC_DIV           (`SWK_CLK_MHZ / `SWK_OSC_MHZ)

`define SWK_CNT_W             11
`define SWK_CNT_MAX           1024
`define SWK_CNT_OUT_DEFAULT   11'h004
`define SWK_CNT_WR_DEFAULT    11'h005
`define SWK_TMR_W             11

`define SWK_T_FILTER_NS       160
`define SWK_T_WPROT_NS        5
`define SWK_T_FLOAT_NS        10
`define SWK_T_WAKE_LOW_NS     7
`define SWK_T_DISABLE_NS      340
`define SWK_T_INPUT_EN_NS     3700
`define SWK_T_WAKE_HIGH_NS    4000

`define SWK_CYC_CEIL(ns)      (((ns) * `SWK_CLK_MHZ + 999) / 1000)
`define SWK_CYC_FLOOR(ns)     ((((ns) * `SWK_CLK_MHZ) / 1000) < 1 ? 1 : \
                               (((ns) * `SWK_CLK_MHZ) / 1000))

`define SWK_CYC_FILTER        `SWK_CYC_CEIL(`SWK_T_FILTER_NS)
`define SWK_CYC_WPROT         `SWK_CYC_FLOOR(`SWK_T_WPROT_NS)
`define SWK_CYC_FLOAT         `SWK_CYC_FLOOR(`SWK_T_FLOAT_NS)
`define SWK_CYC_WAKE_LOW      `SWK_CYC_FLOOR(`SWK_T_WAKE_LOW_NS)
`define SWK_CYC_DISABLE       `SWK_CYC_FLOOR(`SWK_T_DISABLE_NS)
`define SWK_CYC_INPUT_EN      `SWK_CYC_CEIL(`SWK_T_INPUT_EN_NS)
`define SWK_CYC_WAKE_HIGH     `SWK_CYC_CEIL(`SWK_T_WAKE_HIGH_NS)

`define SWK_SYNC_SUSPEND      0
`define SWK_SYNC_RESTART      1
`define SWK_SYNC_WAKE         2
`define SWK_SYNC_WCLK         3
`define SWK_SYNC_N            4

`endif

// ===== rtl/swk_pkg.sv
package swk_pkg;

  typedef enum logic [1:0] {
    SWK_DISABLED            = 2'h0,
    SWK_ENABLED_WITH_FILTER = 2'h1,
    SWK_ENABLED_NO_FILTER   = 2'h2
  } swk_mode_t;

  typedef enum logic [1:0] {
    SWK_HIGH_Z_PLAIN        = 2'h0,
    SWK_HIGH_Z_PULLED_UP    = 2'h1,
    SWK_HIGH_Z_PULLED_DOWN  = 2'h2,
    SWK_HIGH_Z_WITH_KEEPER  = 2'h3
  } swk_highz_t;

  typedef enum logic [5:0] {
    SWK_ST_RUN       = 6'h01,
    SWK_ST_ENTER     = 6'h02,
    SWK_ST_SUSPEND   = 6'h04,
    SWK_ST_EXIT      = 6'h08,
    SWK_ST_WAIT_HIGH = 6'h10,
    SWK_ST_RELEASE   = 6'h20
  } swk_state_t;

endpackage : swk_pkg

// ===== rtl/swk_release_counter.sv
`timescale 1ns/1ps
`include "swk_defines.svh"

module swk_release_counter #(
  parameter int CW = `SWK_CNT_W
) (
  input  wire logic          clk_sys,
  input  wire logic          rstn,
  input  wire logic          clear,
  input  wire logic          start,
  input  wire logic          tick,
  input  wire logic [CW-1:0] target,
  output logic               done
);

  if (CW < `SWK_CNT_W) begin : g_bad_width
    $error("release counter too narrow for 1024 cycles");
  end

  logic          running;
  logic [CW-1:0] cnt;
  logic          next_running;
  logic [CW-1:0] next_cnt;
  logic          next_done;
  logic [CW-1:0] target_eff;

  // a zero count is out of range; treat it as the shortest legal count
  assign target_eff = (target == '0) ? CW'(1) : target;

  always_comb begin
    next_running = running;
    next_cnt     = cnt;
    next_done    = done;
    if (clear) begin
      next_running = 1'b0;
      next_cnt     = '0;
      next_done    = 1'b0;
    end else if (start) begin
      next_running = 1'b1;
      next_cnt     = '0;
      next_done    = 1'b0;
    end else if (running && tick) begin
      next_cnt = cnt + CW'(1);
      if (next_cnt >= target_eff) begin
        next_running = 1'b0;
        next_done    = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      running <= 1'b0;
      cnt     <= '0;
      done    <= 1'b0;
    end else begin
      running <= next_running;
      cnt     <= next_cnt;
      done    <= next_done;
    end
  end

endmodule : swk_release_counter

// ===== rtl/swk_sequencer.sv
`timescale 1ns/1ps
`include "swk_defines.svh"

module swk_sequencer
  import swk_pkg::*;
#(
  parameter int NPINS = 8,
  parameter int CW    = `SWK_CNT_W
) (
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  input  wire logic               suspend_req,
  input  wire logic               config_restart_n,
  input  wire logic               wake_status_in,
  input  wire logic               ext_wake_clk,
  input  wire logic [1:0]         feature_mode,
  input  wire logic               drive_wake_active,
  input  wire logic               global_reset_on_wake_en,
  input  wire logic               wake_clock_select,
  input  wire logic [CW-1:0]      output_release_count,
  input  wire logic [CW-1:0]      write_unlock_count,
  input  wire logic               wake_gpio_out,
  input  wire logic               wake_gpio_oe,
  input  wire logic [NPINS-1:0]   user_out,
  input  wire logic [NPINS-1:0]   user_oe,
  input  wire logic [NPINS-1:0]   pin_hold_last,
  input  wire logic [2*NPINS-1:0] pin_highz_kind,
  input  wire logic [NPINS-1:0]   pin_true_diff,
  output logic                    wake_status_out,
  output logic                    wake_status_oe,
  output logic                    inputs_enabled,
  output logic                    diff_rx_enable,
  output logic                    diff_input_termination_en,
  output logic                    write_allow,
  output logic                    output_float,
  output logic                    global_set_reset,
  output logic                    config_restart,
  output logic                    in_suspend,
  output logic [NPINS-1:0]        pad_out,
  output logic [NPINS-1:0]        pad_oe,
  output logic [NPINS-1:0]        pad_pullup,
  output logic [NPINS-1:0]        pad_pulldown,
  output logic [NPINS-1:0]        pad_keeper
);

  if (NPINS < 1 || CW < `SWK_CNT_W) begin : g_bad_param
    $error("sequencer needs at least one pin and an 11-bit count");
  end

  localparam logic [`SWK_TMR_W-1:0] CYC_FILTER    = `SWK_TMR_W'(`SWK_CYC_FILTER);
  localparam logic [`SWK_TMR_W-1:0] CYC_WPROT     = `SWK_TMR_W'(`SWK_CYC_WPROT);
  localparam logic [`SWK_TMR_W-1:0] CYC_FLOAT     = `SWK_TMR_W'(`SWK_CYC_FLOAT);
  localparam logic [`SWK_TMR_W-1:0] CYC_WAKE_LOW  = `SWK_TMR_W'(`SWK_CYC_WAKE_LOW);
  localparam logic [`SWK_TMR_W-1:0] CYC_DISABLE   = `SWK_TMR_W'(`SWK_CYC_DISABLE);
  localparam logic [`SWK_TMR_W-1:0] CYC_INPUT_EN  = `SWK_TMR_W'(`SWK_CYC_INPUT_EN);
  localparam logic [`SWK_TMR_W-1:0] CYC_WAKE_HIGH = `SWK_TMR_W'(`SWK_CYC_WAKE_HIGH);
  localparam logic [2:0]            OSC_LAST      = 3'(`SWK_OSC_DIV - 1);

  // ---------------- pin synchronisers ----------------
  logic [`SWK_SYNC_N-1:0] sync1;
  logic [`SWK_SYNC_N-1:0] sync2;
  logic                   restart_n_d;
  logic                   wclk_d;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync1       <= 4'h2;
      sync2       <= 4'h2;
      restart_n_d <= 1'b1;
      wclk_d      <= 1'b0;
    end else begin
      sync1       <= {ext_wake_clk, wake_status_in, config_restart_n, suspend_req};
      sync2       <= sync1;
      restart_n_d <= sync2[`SWK_SYNC_RESTART];
      wclk_d      <= sync2[`SWK_SYNC_WCLK];
    end
  end

  logic suspend_s;
  logic restart_low;
  logic restart_fall;
  logic wake_high_s;
  logic ext_tick;

  assign suspend_s    = sync2[`SWK_SYNC_SUSPEND];
  assign restart_low  = !sync2[`SWK_SYNC_RESTART];
  assign restart_fall = restart_n_d && !sync2[`SWK_SYNC_RESTART];
  assign wake_high_s  = sync2[`SWK_SYNC_WAKE];
  assign ext_tick     = sync2[`SWK_SYNC_WCLK] && !wclk_d;

  // ---------------- wake clock source ----------------
  // the oscillator is modelled as a divider; it is imprecise in silicon anyway
  logic [2:0] osc_div;
  logic [2:0] next_osc_div;
  logic       wake_tick;

  always_comb begin
    next_osc_div = (osc_div == OSC_LAST) ? 3'h0 : osc_div + 3'h1;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      osc_div <= 3'h0;
    end else begin
      osc_div <= next_osc_div;
    end
  end

  assign wake_tick = wake_clock_select ? ext_tick : (osc_div == OSC_LAST);

  // ---------------- sequencer ----------------
  swk_state_t                state;
  swk_state_t                next_state;
  logic [`SWK_TMR_W-1:0]     timer;
  logic [`SWK_TMR_W-1:0]     next_timer;
  logic [`SWK_TMR_W-1:0]     timer_inc;
  logic                      next_wake_status_out;
  logic                      next_wake_status_oe;
  logic                      next_inputs_enabled;
  logic                      next_write_allow;
  logic                      next_output_float;
  logic                      next_global_set_reset;
  logic                      next_config_restart;
  logic                      next_in_suspend;
  logic                      capture;
  logic                      cnt_clear;
  logic                      cnt_start;
  logic                      out_done;
  logic                      wr_done;
  logic                      enabled;
  logic                      enabled_with_filter;

  assign timer_inc = timer + `SWK_TMR_W'(1);
  assign enabled   = (feature_mode == SWK_ENABLED_WITH_FILTER) ||
                     (feature_mode == SWK_ENABLED_NO_FILTER);
  assign enabled_with_filter  = (feature_mode == SWK_ENABLED_WITH_FILTER);

  always_comb begin
    next_state            = state;
    next_timer            = timer;
    next_wake_status_out  = wake_status_out;
    next_wake_status_oe   = wake_status_oe;
    next_inputs_enabled   = inputs_enabled;
    next_write_allow      = write_allow;
    next_output_float     = output_float;
    next_global_set_reset = 1'b0;
    next_config_restart   = 1'b0;
    next_in_suspend       = in_suspend;
    capture               = 1'b0;
    cnt_clear             = 1'b0;
    cnt_start             = 1'b0;
    if (restart_low) begin
      // restart wins over any suspend level and returns everything to run
      next_state           = SWK_ST_RUN;
      next_timer           = '0;
      next_config_restart  = restart_fall;
      next_inputs_enabled  = 1'b1;
      next_write_allow     = 1'b1;
      next_output_float    = 1'b0;
      next_in_suspend      = 1'b0;
      next_wake_status_out = enabled ? 1'b1 : wake_gpio_out;
      next_wake_status_oe  = enabled ? 1'b1 : wake_gpio_oe;
      cnt_clear            = 1'b1;
    end else begin
      unique case (state)
        SWK_ST_RUN: begin
          if (!enabled) begin
            // pin belongs to the user design while the feature is off
            next_wake_status_out = wake_gpio_out;
            next_wake_status_oe  = wake_gpio_oe;
            next_timer           = '0;
          end else begin
            next_wake_status_out = 1'b1;
            next_wake_status_oe  = 1'b1;
            if (!suspend_s) begin
              next_timer = '0;
            end else if (!enabled_with_filter || timer_inc >= CYC_FILTER) begin
              // with the filter on, short pulses below the filter length never reach here
              next_state      = SWK_ST_ENTER;
              next_timer      = '0;
              next_in_suspend = 1'b1;
              capture         = 1'b1;
              cnt_clear       = 1'b1;
            end else begin
              next_timer = timer_inc;
            end
          end
        end
        SWK_ST_ENTER: begin
          next_timer = timer_inc;
          if (timer_inc >= CYC_WPROT) begin
            next_write_allow = 1'b0;
          end
          if (timer_inc >= CYC_FLOAT) begin
            next_output_float = 1'b1;
          end
          if (timer_inc >= CYC_WAKE_LOW) begin
            next_wake_status_out = 1'b0;
            next_wake_status_oe  = 1'b1;
          end
          if (timer_inc >= CYC_DISABLE) begin
            next_inputs_enabled = 1'b0;
            next_state          = SWK_ST_SUSPEND;
            next_timer          = '0;
          end
        end
        SWK_ST_SUSPEND: begin
          next_wake_status_out = 1'b0;
          next_wake_status_oe  = 1'b1;
          if (!suspend_s) begin
            next_state = SWK_ST_EXIT;
            next_timer = '0;
          end
        end
        SWK_ST_EXIT: begin
          next_timer = timer_inc;
          if (timer_inc == CYC_INPUT_EN) begin
            next_inputs_enabled   = 1'b1;
            next_global_set_reset = global_reset_on_wake_en;
          end
          if (timer_inc >= CYC_WAKE_HIGH) begin
            // write_allow stays low here so re-enabled inputs corrupt nothing
            next_wake_status_out = 1'b1;
            next_wake_status_oe  = drive_wake_active;
            next_state           = SWK_ST_WAIT_HIGH;
            next_timer           = '0;
          end
        end
        SWK_ST_WAIT_HIGH: begin
          // open-drain case waits for the outside pull-up
          if (wake_high_s) begin
            cnt_start  = 1'b1;
            next_state = SWK_ST_RELEASE;
          end
        end
        SWK_ST_RELEASE: begin
          if (out_done) begin
            next_output_float = 1'b0;
          end
          if (wr_done) begin
            next_write_allow = 1'b1;
          end
          if (out_done && wr_done) begin
            next_state          = SWK_ST_RUN;
            next_in_suspend     = 1'b0;
            next_wake_status_oe = 1'b1;
            cnt_clear           = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state            <= SWK_ST_RUN;
      timer            <= '0;
      wake_status_out  <= 1'b0;
      wake_status_oe   <= 1'b0;
      inputs_enabled   <= 1'b1;
      write_allow      <= 1'b1;
      output_float     <= 1'b0;
      global_set_reset <= 1'b0;
      config_restart   <= 1'b0;
      in_suspend       <= 1'b0;
    end else begin
      state            <= next_state;
      timer            <= next_timer;
      wake_status_out  <= next_wake_status_out;
      wake_status_oe   <= next_wake_status_oe;
      inputs_enabled   <= next_inputs_enabled;
      write_allow      <= next_write_allow;
      output_float     <= next_output_float;
      global_set_reset <= next_global_set_reset;
      config_restart   <= next_config_restart;
      in_suspend       <= next_in_suspend;
    end
  end

  // differential receivers and termination follow the input gate
  assign diff_rx_enable            = inputs_enabled;
  assign diff_input_termination_en = inputs_enabled;

  // ---------------- wake release counters ----------------
  // order between the two is left to the configured counts
  swk_release_counter #(
    .CW (CW)
  ) u_out_release (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .clear   (cnt_clear),
    .start   (cnt_start),
    .tick    (wake_tick),
    .target  (output_release_count),
    .done    (out_done)
  );

  swk_release_counter #(
    .CW (CW)
  ) u_write_unlock (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .clear   (cnt_clear),
    .start   (cnt_start),
    .tick    (wake_tick),
    .target  (write_unlock_count),
    .done    (wr_done)
  );

  // ---------------- per-pin suspend behaviour ----------------
  for (genvar i = 0; i < NPINS; i++) begin : g_pin
    logic       last_val;
    logic       next_last_val;
    logic       hold;
    swk_highz_t kind;
    logic       n_out;
    logic       n_oe;
    logic       n_pu;
    logic       n_pd;
    logic       n_kp;

    assign kind = swk_highz_t'(pin_highz_kind[2*i +: 2]);
    // true differential drivers cannot hold a level
    assign hold = pin_hold_last[i] && !pin_true_diff[i];

    always_comb begin
      next_last_val = capture ? user_out[i] : last_val;
      n_out         = user_out[i];
      n_oe          = user_oe[i];
      n_pu          = 1'b0;
      n_pd          = 1'b0;
      n_kp          = 1'b0;
      if (output_float) begin
        n_out = hold ? last_val : 1'b0;
        n_oe  = hold;
        n_pu  = !hold && (kind == SWK_HIGH_Z_PULLED_UP);
        n_pd  = !hold && (kind == SWK_HIGH_Z_PULLED_DOWN);
        n_kp  = !hold && (kind == SWK_HIGH_Z_WITH_KEEPER);
      end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        last_val        <= 1'b0;
        pad_out[i]      <= 1'b0;
        pad_oe[i]       <= 1'b0;
        pad_pullup[i]   <= 1'b0;
        pad_pulldown[i] <= 1'b0;
        pad_keeper[i]   <= 1'b0;
      end else begin
        last_val        <= next_last_val;
        pad_out[i]      <= n_out;
        pad_oe[i]       <= n_oe;
        pad_pullup[i]   <= n_pu;
        pad_pulldown[i] <= n_pd;
        pad_keeper[i]   <= n_kp;
      end
    end
  end

endmodule : swk_sequencer

// ===== verification/swk_sequencer_monitor.sv
`timescale 1ns/1ps
module swk_sequencer_monitor #(
  parameter int NPINS = 8,
  parameter int CW    = 11
) (
  input wire logic             clk_sys,
  input wire logic             rstn,
  input wire logic             config_restart_n,
  input wire logic             wake_status_in,
  input wire logic             drive_wake_active,
  input wire logic             global_reset_on_wake_en,
  input wire logic [CW-1:0]    output_release_count,
  input wire logic [CW-1:0]    write_unlock_count,
  input wire logic [NPINS-1:0] pin_hold_last,
  input wire logic [NPINS-1:0] pin_true_diff,
  input wire logic             wake_status_out,
  input wire logic             wake_status_oe,
  input wire logic             inputs_enabled,
  input wire logic             diff_rx_enable,
  input wire logic             write_allow,
  input wire logic             output_float,
  input wire logic             global_set_reset,
  input wire logic             config_restart,
  input wire logic             in_suspend,
  input wire logic [NPINS-1:0] pad_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic [12:0] wcyc;
  function automatic int eff(input logic [CW-1:0] c);
    return (c == '0) ? 1 : int'(c);
  endfunction : eff
  // wake-clock phase and two sync stages leave a few clocks of slack
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) wcyc <= '0;
    else if (!(wake_status_in && in_suspend)) wcyc <= '0;
    else if (!(&wcyc)) wcyc <= wcyc + 13'h0001;
  end
  wprot_float_a: assert property (
    $fell(write_allow) |-> !wake_status_out ##1 $rose(output_float))
    else $error("entry order wrong");
  inputs_off_a: assert property (
    $rose(output_float) |-> ##83 $fell(inputs_enabled))
    else $error("inputs not cut on time");
  diff_off_a: assert property (
    !diff_rx_enable == (in_suspend && !inputs_enabled))
    else $error("diff receiver not off in suspend");
  gated_exit_a: assert property (
    $rose(inputs_enabled) && !write_allow |->
    output_float && global_set_reset == global_reset_on_wake_en)
    else $error("exit state wrong");
  wake_drive_a: assert property (
    $rose(inputs_enabled) && !write_allow |->
    ##75 $rose(wake_status_out) && wake_status_oe == drive_wake_active)
    else $error("wake drive wrong");
  float_count_a: assert property (
    $fell(output_float) && !write_allow && config_restart_n |->
    wcyc >= 5 * eff(output_release_count) - 4 && wcyc <= 5 * eff(output_release_count) + 8)
    else $error("output release time wrong");
  write_count_a: assert property (
    $rose(write_allow) && config_restart_n |->
    wcyc >= 5 * eff(write_unlock_count) - 4 && wcyc <= 5 * eff(write_unlock_count) + 8)
    else $error("write unlock time wrong");
  restart_pulse_a: assert property (
    $fell(config_restart_n) |-> ##[1:4] config_restart)
    else $error("restart pulse missing");
  restart_hold_a: assert property (
    !config_restart_n && !$past(config_restart_n, 4) |->
    !in_suspend && write_allow && inputs_enabled && !output_float)
    else $error("restart ignored");
  pad_float_a: assert property (
    $past(output_float) |-> pad_oe == ($past(pin_hold_last) & ~$past(pin_true_diff)))
    else $error("pad drive wrong");
  cover property ($rose(global_set_reset));
  cover property ($rose(config_restart));
  cover property (in_suspend && !wake_status_oe && wake_status_in);
endmodule : swk_sequencer_monitor

bind swk_sequencer swk_sequencer_monitor #(.NPINS(NPINS), .CW(CW)) u_mon (.*);

// ===== verification/swk_ctrl_model.sv
`timescale 1ns/1ps
module swk_ctrl_model (
  input  wire logic       clk_sys,
  input  wire logic       go,
  input  wire logic       wake_status_out,
  input  wire logic       wake_status_oe,
  input  wire logic [3:0] pu_dly,
  output logic            suspend_req,
  output logic            wake_status_in
);
  logic [3:0] rel = 4'h0;
  // request is low in normal use and is dropped to leave suspend
  assign suspend_req = go;
  // slow resistor: a released line reaches high only after pu_dly clocks
  always @(posedge clk_sys)
    rel <= wake_status_oe ? 4'h0 : ((rel == 4'hF) ? rel : rel + 4'h1);
  assign wake_status_in = wake_status_oe ? wake_status_out : (rel >= pu_dly);
endmodule : swk_ctrl_model

// ===== verification/swk_sequencer_tb_top.sv
`timescale 1ns/1ps
module swk_sequencer_tb_top
  import swk_pkg::*;
;
  logic clk_sys, rstn, go, config_restart_n, ext_wake_clk, suspend_req, wake_status_in;
  logic drive_wake_active, global_reset_on_wake_en, wake_clock_select, wake_gpio_out;
  logic wake_gpio_oe, wake_status_out, wake_status_oe, inputs_enabled, diff_rx_enable;
  logic diff_input_termination_en, write_allow, output_float, global_set_reset;
  logic config_restart, in_suspend, wa_q, wo_q;
  logic [1:0]  feature_mode;
  logic [3:0]  pu_dly;
  logic [10:0] output_release_count, write_unlock_count;
  logic [7:0]  user_out, user_oe, pin_hold_last, pin_true_diff, pad_out, pad_oe;
  logic [7:0]  pad_pullup, pad_pulldown, pad_keeper;
  logic [15:0] pin_highz_kind;
  logic [2:0]  seen;
  logic [2:0]  exp_q[$];
  logic [31:0] rs;
  int          n_errors, checked, cyc;

  swk_sequencer dut (.*);
  swk_ctrl_model u_ctl (.*);

  always #2 clk_sys = ~clk_sys;
  initial begin
    ext_wake_clk = 1'b0;
    #0.7;
    forever #10 ext_wake_clk = ~ext_wake_clk;
  end

  task automatic print_verdict();
    // a wake record that never closed is a lost result
    if (exp_q.size() != 0) n_errors++;
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic cmp3(input string nm, input logic [2:0] e, input logic [2:0] s);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp3

  task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp32

  // suspend form of the pads: {out, pull-up, pull-down, keeper}
  function automatic logic [31:0] pad_exp();
    logic h;
    pad_exp = '0;
    for (int i = 0; i < 8; i++) begin
      h = pin_hold_last[i] & ~pin_true_diff[i];
      pad_exp[24+i] = h & user_out[i];
      pad_exp[16+i] = !h && (pin_highz_kind[2*i +: 2] == 2'h1);
      pad_exp[8+i]  = !h && (pin_highz_kind[2*i +: 2] == 2'h2);
      pad_exp[i]    = !h && (pin_highz_kind[2*i +: 2] == 2'h3);
    end
  endfunction : pad_exp

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd

  task automatic wait_for(ref logic s, input logic v);
    repeat (9000) begin
      @(posedge clk_sys);
      #1;
      if (s === v) break;
    end
    if (s !== v) n_errors++;
  endtask : wait_for

  task automatic cfg(input logic [1:0] md, input logic dr, gs, sel,
                     input logic [10:0] oc, wc, input logic [3:0] pd);
    @(posedge clk_sys);
    #1;
    {feature_mode, drive_wake_active} = {md, dr};
    {global_reset_on_wake_en, wake_clock_select} = {gs, sel};
    {output_release_count, write_unlock_count, pu_dly} = {oc, wc, pd};
    {user_out, user_oe, pin_hold_last, pin_true_diff} = rnd();
    {pin_highz_kind, wake_gpio_out, wake_gpio_oe} = 18'(rnd());
  endtask : cfg

  task automatic wake(input logic [1:0] md, input logic dr, gs, sel,
                      input logic [10:0] oc, wc, input logic [3:0] pd);
    cfg(md, dr, gs, sel, oc, wc, pd);
    exp_q.push_back({1'b0, gs, dr});
    go = 1'b1;
    wait_for(inputs_enabled, 1'b0);
    cmp3("suspend", 3'h1, {1'b0, diff_input_termination_en, in_suspend});
    cmp32("pads", pad_exp(), {pad_out, pad_pullup, pad_pulldown, pad_keeper});
    go = 1'b0;
    wait_for(write_allow, 1'b1);
    // the user side resets its clock managers here; the bench has none
    $display("wake test done mode %0d", md);
  endtask : wake

  task automatic ignore(input logic [1:0] md, input int len);
    logic hit;
    logic dis;
    cfg(md, 1'b0, 1'b0, 1'b0, 11'h004, 11'h005, 4'h0);
    hit = 1'b0;
    dis = (md == SWK_DISABLED) || (md == 2'h3);
    go = 1'b1;
    // a pulse shorter than the filter must not start an entry
    repeat (len) begin
      @(posedge clk_sys);
      hit = hit | in_suspend;
    end
    #1 go = 1'b0;
    repeat (60) begin
      @(posedge clk_sys);
      hit = hit | in_suspend;
    end
    #1;
    cmp3("ignored", {1'b0, dis ? {wake_gpio_oe, wake_gpio_out} : 2'h3},
         {hit, wake_status_oe, wake_status_out});
    $display("ignore test done mode %0d", md);
  endtask : ignore

  task automatic restart();
    cfg(SWK_ENABLED_NO_FILTER, 1'b1, 1'b0, 1'b0, 11'h004, 11'h005, 4'h0);
    exp_q.push_back(3'h4);
    go = 1'b1;
    wait_for(inputs_enabled, 1'b0);
    config_restart_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 go = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 config_restart_n = 1'b1;
    repeat (20) @(posedge clk_sys);
    $display("restart test done");
  endtask : restart

  // a record closes when the write lock lifts
  always @(posedge clk_sys) begin
    if (config_restart === 1'b1) seen[2] = 1'b1;
    if (global_set_reset === 1'b1) seen[1] = 1'b1;
    if (wake_status_out === 1'b1 && wo_q === 1'b0 && write_allow === 1'b0) seen[0] = wake_status_oe;
    if (write_allow === 1'b1 && wa_q === 1'b0) begin
      cmp3("wake record", exp_q.size() ? exp_q.pop_front() : 3'hX, seen);
      seen = 3'h0;
    end
    wa_q = write_allow;
    wo_q = wake_status_out;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      print_verdict();
    end
  end

  initial begin
    {clk_sys, rstn, go, config_restart_n, wa_q, wo_q, seen, rs} = {6'h06, 3'h0, 32'h0000002F};
    {n_errors, checked, cyc} = {32'h0, 32'h0, 32'h0};
    {feature_mode, drive_wake_active, global_reset_on_wake_en, wake_clock_select} = 5'h0;
    {output_release_count, write_unlock_count, pu_dly} = {11'h004, 11'h005, 4'h0};
    {user_out, user_oe, pin_hold_last, pin_true_diff} = 32'h0;
    {pin_highz_kind, wake_gpio_out, wake_gpio_oe} = 18'h0;
    repeat (16) @(posedge clk_sys);
    #1 rstn = 1'b1;
    repeat (4) @(posedge clk_sys);
    // release counts never let the write lock lift before the outputs
    wake(SWK_ENABLED_NO_FILTER, 1'b1, 1'b0, 1'b0, 11'h004, 11'h005, 4'h0);
    wake(SWK_ENABLED_WITH_FILTER, 1'b0, 1'b1, 1'b1, 11'h001, 11'h001, 4'h7);
    wake(SWK_ENABLED_NO_FILTER, 1'b1, 1'b1, 1'b0, 11'h000, 11'h003, 4'h0);
    wake(SWK_ENABLED_WITH_FILTER, 1'b0, 1'b0, 1'b0, 11'h010, 11'h400, 4'h2);
    ignore(SWK_ENABLED_WITH_FILTER, 30);
    ignore(SWK_DISABLED, 200);
    ignore(2'h3, 200);
    restart();
    print_verdict();
  end
endmodule : swk_sequencer_tb_top
